// File: rtl/mmac_calc.sv
// Min/max/average value calculator core
//
// Notes on behaviour
// - Output max, min or mean of inputs.
// - Two to eight inputs; only configured ones count.
// - One shared value format for all objects.
// - Update mode sends on every input telegram.
// - Change mode sends only when result differs.
// - Restart mode: use inputs received since restart.
// - Block mode: no output until all inputs seen.
// - Read mode: request every input, use answers.
// - Optional send delay, 1-255 time units.
// - Optional cyclic repeat, 1-255 time units.
// - Optional lock input disables the function.
// - Lock state on bus return: four choices.
// - Read lock on return; unanswered means unlocked.
`timescale 1ns/1ps
module mmac_calc #(
    parameter int unsigned TICK_CYCLES = mmac_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Bus voltage return event
    input wire logic bus_return,
    // Input value telegrams
    input wire logic in_valid,
    input wire logic [2:0] in_idx,
    input wire logic [31:0] in_value,
    // Lock telegrams
    input wire logic lock_valid,
    input wire logic lock_value,
    // Output telegram
    output logic out_valid,
    output logic [31:0] out_value,
    // Read requests towards the bus
    output logic rdreq_valid,
    output logic [3:0] rdreq_obj
);
    import mmac_pkg::*;

    // Prescaler width, one bit at least
    localparam int PRE_W = (TICK_CYCLES > 2) ? $clog2(TICK_CYCLES) : 1;

    typedef enum logic [1:0] {ST_IDLE, ST_SCAN, ST_DONE} mmac_state_e;

    // Mask of configured inputs
    function automatic logic [7:0] in_mask(input logic [3:0] n);
        logic [7:0] m;
        m = '0;
        for (int i = 0; i < MAX_INPUTS; i++) begin
            m[i] = (i < n);
        end
        return m;
    endfunction

    // Ticks for a value and unit; zero acts as one
    function automatic logic [TMR_W-1:0] ticks_of(input logic [7:0] v,
                                                 input logic [1:0] u);
        int unsigned mult;
        int unsigned val;
        val = (v == 8'h00) ? 1 : int'(v);
        case (u)
            UNIT_SEC: mult = 1;
            UNIT_MIN: mult = SEC_PER_MIN;
            UNIT_HOUR: mult = SEC_PER_HOUR;
            default: mult = SEC_PER_DAY;
        endcase
        return TMR_W'(val * mult / TICK_PERIOD_S);
    endfunction

    // Number for comparing, and for summing except F32
    function automatic logic signed [NUM_W-1:0] decode(input logic [31:0] r,
                                                      input logic [2:0] f);
        case (f)
            FMT_S8: return NUM_W'($signed(r[7:0]));
            FMT_U16: return $signed(NUM_W'(r[15:0]));
            FMT_S16: return NUM_W'($signed(r[15:0]));
            FMT_F16: return NUM_W'($signed({r[15], r[10:0]})) <<< r[14:11];
            FMT_U32: return $signed(NUM_W'(r));
            FMT_F32: return r[31] ? -$signed(NUM_W'(r[30:0]))
                                  : $signed(NUM_W'(r[30:0]));
            default: return $signed(NUM_W'(r[7:0]));
        endcase
    endfunction

    // Float to integer, truncating toward zero
    function automatic logic signed [NUM_W-1:0] f32_to_int(input logic [31:0] f);
        logic [NUM_W-1:0] m;
        logic signed [NUM_W-1:0] r;
        m = {{(NUM_W-24){1'b0}}, 1'b1, f[22:0]};
        if (int'(f[30:23]) < F32_BIAS) begin
            r = '0;
        end else if (int'(f[30:23]) >= F32_BIAS + F32_MANT) begin
            r = $signed(m << (int'(f[30:23]) - F32_BIAS - F32_MANT));
        end else begin
            r = $signed(m >> (F32_BIAS + F32_MANT - int'(f[30:23])));
        end
        return f[31] ? -r : r;
    endfunction

    // Integer to single float, truncated
    function automatic logic [31:0] int_to_f32(input logic signed [NUM_W-1:0] v);
        logic [NUM_W-1:0] a;
        logic [NUM_W-1:0] n;
        int p;
        a = v[NUM_W-1] ? NUM_W'(-v) : NUM_W'(v);
        p = 0;
        for (int i = 0; i < NUM_W; i++) begin
            if (a[i]) p = i;
        end
        n = (p > F32_MANT) ? (a >> (p - F32_MANT)) : (a << (F32_MANT - p));
        if (a == '0) return 32'h0;
        return {v[NUM_W-1], 8'(F32_BIAS + p), n[22:0]};
    endfunction

    // Number to raw value of the format
    function automatic logic [31:0] encode(input logic signed [NUM_W-1:0] v,
                                          input logic [2:0] f);
        logic signed [NUM_W-1:0] m;
        logic [3:0] e;
        m = v;
        e = '0;
        case (f)
            FMT_U16, FMT_S16: return {16'h0, v[15:0]};
            FMT_U32: return v[31:0];
            FMT_F32: return int_to_f32(v);
            FMT_F16: begin
                // Halve until the mantissa fits; precision lost, not range
                for (int i = 0; i < F16_EXP_MAX; i++) begin
                    if (m > F16_M_MAX || m < F16_M_MIN) begin
                        m = m >>> 1;
                        e = e + 4'h1;
                    end
                end
                return {16'h0, m[11], e, m[10:0]};
            end
            default: return {24'h0, v[7:0]};
        endcase
    endfunction

    // Register port state
    mmac_cfg_s cfg_q, cfg_d; // Configuration
    mmac_time_s tim_q, tim_d; // Delay and cycle values
    logic [31:0] rdata_q, rdata_d; // Read data, one cycle late

    // Calculator state
    logic [31:0] raw_q [MAX_INPUTS]; // Held input values
    logic [31:0] raw_d [MAX_INPUTS];
    logic [7:0] got_q, got_d; // Inputs received since restart
    logic pend_q, pend_d; // Recalculation wanted
    mmac_state_e st_q, st_d; // Scan state
    logic [2:0] idx_q, idx_d; // Input under scan
    logic signed [NUM_W-1:0] best_q, best_d; // Best number so far
    logic [31:0] braw_q, braw_d; // Raw value of the best
    logic signed [NUM_W-1:0] sum_q, sum_d; // Running sum
    logic [3:0] cnt_q, cnt_d; // Inputs taken part
    logic [31:0] res_q, res_d; // Last computed result
    logic res_valid_q, res_valid_d; // A result exists
    logic dly_pend_q, dly_pend_d; // Delayed send armed
    logic [TMR_W-1:0] dly_cnt_q, dly_cnt_d; // Delay ticks left
    logic [TMR_W-1:0] cyc_cnt_q, cyc_cnt_d; // Cycle ticks left
    logic [PRE_W-1:0] pre_q, pre_d; // Second prescaler
    logic tick_q, tick_d; // One-second pulse
    logic lock_q, lock_d; // Lock object value
    logic lwait_q, lwait_d; // Awaiting lock answer
    logic [LCK_W-1:0] lcnt_q, lcnt_d; // Lock answer ticks left
    logic [8:0] rd_pend_q, rd_pend_d; // Read requests still to issue
    logic rdv_q, rdv_d; // Read request pulse
    logic [3:0] rdo_q, rdo_d; // Read request object
    logic outv_q, outv_d; // Output telegram pulse
    logic [31:0] outd_q, outd_d; // Output telegram value

    // Derived conditions
    logic [7:0] mask;
    logic locked;
    logic blocked;
    logic can_send;
    mmac_stat_s stat;

    assign mask = in_mask(cfg_q.n_in);
    // Waiting for a lock answer also holds output back
    assign locked = cfg_q.lock_en && (lock_q || lwait_q);
    assign blocked = (cfg_q.restart == RST_BLOCK)
                     && ((got_q & mask) != mask);
    assign can_send = !blocked && !locked;
    assign stat = '{rsvd: 16'h0, got: got_q, rsvd2: 4'h0,
                    dly_pend: dly_pend_q, res_valid: res_valid_q,
                    blocked: blocked, locked: locked};

    // Register port next values
    always_comb begin
        mmac_cfg_s w;
        w = mmac_cfg_s'(reg_wdata);
        cfg_d = cfg_q;
        tim_d = tim_q;
        rdata_d = 32'h0;
        if (reg_wr) begin
            case (reg_addr)
                ADDR_CFG: begin
                    // Clamp input count so the mask stays meaningful
                    w.rsvd = '0;
                    if (w.n_in < 4'(MIN_INPUTS)) w.n_in = 4'(MIN_INPUTS);
                    if (w.n_in > 4'(MAX_INPUTS)) w.n_in = 4'(MAX_INPUTS);
                    cfg_d = w;
                end
                ADDR_TIME: begin
                    tim_d = mmac_time_s'(reg_wdata);
                    tim_d.rsvd = '0;
                end
                default: begin
                    // Unmapped writes are dropped
                end
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                ADDR_CFG: rdata_d = cfg_q;
                ADDR_TIME: rdata_d = tim_q;
                ADDR_STAT: rdata_d = stat;
                ADDR_RES: rdata_d = res_q;
                default: rdata_d = 32'h0;
            endcase
        end
    end

    // Register port flops
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cfg_q <= CFG_RST;
            tim_q <= TIME_RST;
            rdata_q <= 32'h0;
        end else begin
            cfg_q <= cfg_d;
            tim_q <= tim_d;
            rdata_q <= rdata_d;
        end
    end

    // Calculator next values
    always_comb begin
        logic snd;
        logic [31:0] snd_val;
        logic signed [NUM_W-1:0] num;
        logic [31:0] nres;
        int sel;
        snd = 1'b0;
        snd_val = res_q;
        num = '0;
        nres = '0;
        sel = 0;
        raw_d = raw_q;
        got_d = got_q;
        pend_d = pend_q;
        st_d = st_q;
        idx_d = idx_q;
        best_d = best_q;
        braw_d = braw_q;
        sum_d = sum_q;
        cnt_d = cnt_q;
        res_d = res_q;
        res_valid_d = res_valid_q;
        dly_pend_d = dly_pend_q;
        dly_cnt_d = dly_cnt_q;
        cyc_cnt_d = cyc_cnt_q;
        lock_d = lock_q;
        lwait_d = lwait_q;
        lcnt_d = lcnt_q;
        rd_pend_d = rd_pend_q;
        rdv_d = 1'b0;
        rdo_d = rdo_q;
        outv_d = 1'b0;
        outd_d = outd_q;

        // One-second tick from the clock
        if (pre_q == PRE_W'(TICK_CYCLES - 1)) begin
            pre_d = '0;
            tick_d = 1'b1;
        end else begin
            pre_d = pre_q + PRE_W'(1);
            tick_d = 1'b0;
        end

        // Delayed send expires on a tick
        if (dly_pend_q && tick_q) begin
            if (dly_cnt_q <= TMR_W'(1)) begin
                dly_pend_d = 1'b0;
                snd = can_send;
            end else begin
                dly_cnt_d = dly_cnt_q - TMR_W'(1);
            end
        end

        // Cyclic repeat
        if (cfg_q.cyc_en && res_valid_q && tick_q) begin
            if (cyc_cnt_q <= TMR_W'(1)) begin
                cyc_cnt_d = ticks_of(tim_q.cyc_val, cfg_q.cyc_unit);
                snd = snd || can_send;
            end else begin
                cyc_cnt_d = cyc_cnt_q - TMR_W'(1);
            end
        end

        // Scan over the inputs, one per cycle
        case (st_q)
            ST_IDLE: begin
                if (pend_q) begin
                    pend_d = 1'b0;
                    st_d = ST_SCAN;
                    idx_d = '0;
                    cnt_d = '0;
                    sum_d = '0;
                end
            end
            ST_SCAN: begin
                // Configured inputs seen since restart
                if (mask[idx_q] && got_q[idx_q]) begin
                    num = decode(raw_q[idx_q], cfg_q.fmt);
                    if (cnt_q == 4'h0
                        || (cfg_q.mode == MODE_MIN ? num < best_q
                                                   : num > best_q)) begin
                        best_d = num;
                        braw_d = raw_q[idx_q];
                    end
                    // Sum wraps past signed NUM_W bits; three large U32 values already do
                    sum_d = sum_q + ((cfg_q.fmt == FMT_F32)
                        ? f32_to_int(raw_q[idx_q]) : num);
                    cnt_d = cnt_q + 4'h1;
                end
                st_d = (idx_q == 3'(MAX_INPUTS - 1)) ? ST_DONE : ST_SCAN;
                idx_d = idx_q + 3'h1;
            end
            ST_DONE: begin
                st_d = ST_IDLE;
                if (cnt_q != 4'h0) begin
                    nres = (cfg_q.mode == MODE_AVG)
                        ? encode(sum_q / $signed(NUM_W'(cnt_q)), cfg_q.fmt)
                        : braw_q;
                    res_d = nres;
                    res_valid_d = 1'b1;
                    // Change mode: against previous result
                    if ((!cfg_q.on_change
                         || !res_valid_q || nres != res_q)
                        && can_send) begin
                        if (cfg_q.dly_en) begin
                            // A newer result restarts the delay
                            dly_pend_d = 1'b1;
                            dly_cnt_d = ticks_of(tim_q.dly_val,
                                                 cfg_q.dly_unit);
                        end else begin
                            snd = 1'b1;
                            snd_val = nres;
                        end
                    end
                end
            end
            default: st_d = ST_IDLE;
        endcase

        // Input telegram; set wins over the scan start clear
        if (in_valid && mask[in_idx]) begin
            raw_d[in_idx] = in_value;
            got_d[in_idx] = 1'b1;
            pend_d = 1'b1;
        end

        // Lock telegram ends the answer wait
        if (lock_valid && cfg_q.lock_en) begin
            lock_d = lock_value;
            lwait_d = 1'b0;
        end else if (lwait_q && tick_q) begin
            if (lcnt_q <= LCK_W'(1)) begin
                lwait_d = 1'b0;
                lock_d = 1'b0;
            end else begin
                lcnt_d = lcnt_q - LCK_W'(1);
            end
        end

        // Pending read requests, lowest first
        for (int i = 8; i >= 0; i--) begin
            if (rd_pend_q[i]) sel = i;
        end
        if (rd_pend_q != 9'h0) begin
            rdv_d = 1'b1;
            rdo_d = 4'(sel);
            rd_pend_d[sel] = 1'b0;
        end

        // Send the output telegram
        if (snd) begin
            outv_d = 1'b1;
            outd_d = snd_val;
            cyc_cnt_d = ticks_of(tim_q.cyc_val, cfg_q.cyc_unit);
        end

        // Bus return restarts the function
        if (bus_return) begin
            got_d = '0;
            pend_d = 1'b0;
            st_d = ST_IDLE;
            res_valid_d = 1'b0;
            dly_pend_d = 1'b0;
            lwait_d = 1'b0;
            rd_pend_d = '0;
            if (cfg_q.restart == RST_READ) begin
                rd_pend_d[7:0] = mask;
            end
            if (cfg_q.lock_en) begin
                case (cfg_q.lock_restart)
                    LOCK_OPEN: lock_d = 1'b0;
                    LOCK_SHUT: lock_d = 1'b1;
                    LOCK_READ: begin
                        lock_d = 1'b0;
                        lwait_d = 1'b1;
                        lcnt_d = LCK_W'(LOCK_WAIT_TICKS);
                        rd_pend_d[RD_OBJ_LOCK] = 1'b1;
                    end
                    default: lock_d = lock_q;
                endcase
            end
        end
    end

    // Calculator flops
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            for (int i = 0; i < MAX_INPUTS; i++) begin
                raw_q[i] <= 32'h0;
            end
            got_q <= '0;
            pend_q <= 1'b0;
            st_q <= ST_IDLE;
            idx_q <= '0;
            best_q <= '0;
            braw_q <= 32'h0;
            sum_q <= '0;
            cnt_q <= '0;
            res_q <= 32'h0;
            res_valid_q <= 1'b0;
            dly_pend_q <= 1'b0;
            dly_cnt_q <= '0;
            cyc_cnt_q <= '0;
            pre_q <= '0;
            tick_q <= 1'b0;
            lock_q <= 1'b0;
            lwait_q <= 1'b0;
            lcnt_q <= '0;
            rd_pend_q <= '0;
            rdv_q <= 1'b0;
            rdo_q <= 4'h0;
            outv_q <= 1'b0;
            outd_q <= 32'h0;
        end else begin
            raw_q <= raw_d;
            got_q <= got_d;
            pend_q <= pend_d;
            st_q <= st_d;
            idx_q <= idx_d;
            best_q <= best_d;
            braw_q <= braw_d;
            sum_q <= sum_d;
            cnt_q <= cnt_d;
            res_q <= res_d;
            res_valid_q <= res_valid_d;
            dly_pend_q <= dly_pend_d;
            dly_cnt_q <= dly_cnt_d;
            cyc_cnt_q <= cyc_cnt_d;
            pre_q <= pre_d;
            tick_q <= tick_d;
            lock_q <= lock_d;
            lwait_q <= lwait_d;
            lcnt_q <= lcnt_d;
            rd_pend_q <= rd_pend_d;
            rdv_q <= rdv_d;
            rdo_q <= rdo_d;
            outv_q <= outv_d;
            outd_q <= outd_d;
        end
    end

    // Outputs straight from flops
    assign reg_rdata = rdata_q;
    assign out_valid = outv_q;
    assign out_value = outd_q;
    assign rdreq_valid = rdv_q;
    assign rdreq_obj = rdo_q;

endmodule

// File: rtl/mmac_pkg.sv
// Shared constants and types of the calculator
package mmac_pkg;

    // Clock rate and the one-second time base
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned TICK_PERIOD_S = 1;
    localparam int unsigned TICK_CYCLES = TICK_PERIOD_S * CLK_HZ;

    // Lock answer wait, in seconds
    localparam int unsigned LOCK_WAIT_S = 5;
    localparam int unsigned LOCK_WAIT_TICKS = LOCK_WAIT_S / TICK_PERIOD_S;

    // Unit multipliers in seconds
    localparam int unsigned SEC_PER_MIN = 60;
    localparam int unsigned SEC_PER_HOUR = 3600;
    localparam int unsigned SEC_PER_DAY = 86400;

    // Input count limits and widths
    localparam int MIN_INPUTS = 2;
    localparam int MAX_INPUTS = 8;
    localparam int NUM_W = 34;
    localparam int TMR_W = 25;
    localparam int LCK_W = 8;

    // Float field constants
    localparam int F16_EXP_MAX = 15;
    localparam int F16_M_MAX = 2047;
    localparam int F16_M_MIN = -2048;
    localparam int F32_BIAS = 127;
    localparam int F32_MANT = 23;

    // Register word addresses
    localparam logic [3:0] ADDR_CFG = 4'h0;
    localparam logic [3:0] ADDR_TIME = 4'h1;
    localparam logic [3:0] ADDR_STAT = 4'h2;
    localparam logic [3:0] ADDR_RES = 4'h3;

    // Object index of the lock in read requests
    localparam logic [3:0] RD_OBJ_LOCK = 4'h8;

    // Enumerated choices
    typedef enum logic [1:0] {MODE_MAX, MODE_MIN, MODE_AVG, MODE_RSVD} mmac_mode_e;
    typedef enum logic [2:0] {
        FMT_PCT, FMT_U8, FMT_S8, FMT_U16, FMT_S16, FMT_F16, FMT_U32, FMT_F32
    } mmac_fmt_e;
    typedef enum logic [1:0] {RST_RECEIVED, RST_BLOCK, RST_READ, RST_RSVD} mmac_rst_e;
    typedef enum logic [1:0] {LOCK_OPEN, LOCK_SHUT, LOCK_READ, LOCK_KEEP} mmac_lock_e;
    typedef enum logic [1:0] {UNIT_SEC, UNIT_MIN, UNIT_HOUR, UNIT_DAY} mmac_unit_e;

    // Configuration register layout
    typedef struct packed {
        logic [10:0] rsvd;
        logic [1:0] lock_restart;
        logic lock_en;
        logic [1:0] cyc_unit;
        logic cyc_en;
        logic [1:0] dly_unit;
        logic dly_en;
        logic [1:0] restart;
        logic on_change;
        logic [2:0] fmt;
        logic [3:0] n_in;
        logic [1:0] mode;
    } mmac_cfg_s;

    // Time register layout
    typedef struct packed {
        logic [15:0] rsvd;
        logic [7:0] cyc_val;
        logic [7:0] dly_val;
    } mmac_time_s;

    // Status register layout
    typedef struct packed {
        logic [15:0] rsvd;
        logic [7:0] got;
        logic [3:0] rsvd2;
        logic dly_pend;
        logic res_valid;
        logic blocked;
        logic locked;
    } mmac_stat_s;

    // Reset values
    localparam mmac_cfg_s CFG_RST = '{rsvd: 11'h0, lock_restart: LOCK_OPEN,
        lock_en: 1'b0, cyc_unit: UNIT_MIN, cyc_en: 1'b0, dly_unit: UNIT_MIN,
        dly_en: 1'b0, restart: RST_RECEIVED, on_change: 1'b0, fmt: FMT_PCT,
        n_in: 4'h2, mode: MODE_MAX};
    localparam mmac_time_s TIME_RST = '{rsvd: 16'h0, cyc_val: 8'h01,
        dly_val: 8'h01};

endpackage

// File: test/mmac_bus_model.sv
// Bus model: telegrams and read answers
`timescale 1ns/1ps
module mmac_bus_model (
    // Device side
    input wire logic mclk,
    input wire logic rdreq_valid,
    input wire logic [3:0] rdreq_obj,
    // Bench telegrams
    input wire logic t_valid,
    input wire logic [2:0] t_idx,
    input wire logic [31:0] t_val,
    // Toward the device
    output logic in_valid,
    output logic [2:0] in_idx,
    output logic [31:0] in_value
);
    logic ans_q = 1'b0; // Answer due
    logic [2:0] obj_q = 3'h0; // Object being answered
    // Inputs answer; lock stays silent
    always_ff @(posedge mclk) begin
        ans_q <= rdreq_valid && !rdreq_obj[3];
        obj_q <= rdreq_obj[2:0];
    end
    // Bench stays off answers
    always_comb begin
        in_valid = t_valid | ans_q;
        in_idx = ans_q ? obj_q : t_idx;
        in_value = ans_q ? {25'h0, obj_q, 4'h5} : t_val;
    end
endmodule

// File: test/mmac_calc_properties.sv
// Port checker for the value calculator
`timescale 1ns/1ps
module mmac_calc_properties
    import mmac_pkg::*;
#(parameter int unsigned TICK_CYCLES = 4) (
    // Clock, reset, register port
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // Telegrams
    input wire logic bus_return,
    input wire logic in_valid,
    input wire logic [2:0] in_idx,
    input wire logic [31:0] in_value,
    input wire logic lock_valid,
    input wire logic lock_value,
    input wire logic out_valid,
    input wire logic [31:0] out_value,
    input wire logic rdreq_valid,
    input wire logic [3:0] rdreq_obj
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    mmac_cfg_s cfg_q; // Config shadow
    // Tracks the mode
    always_ff @(posedge mclk) begin
        if (sys_rst) cfg_q <= CFG_RST;
        else if (reg_wr && reg_addr == ADDR_CFG) cfg_q <= reg_wdata;
    end
    rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("stray read data");
    rd_unmap_a: assert property (reg_rd && reg_addr > ADDR_RES
        |=> reg_rdata == 32'h0) else $error("unmapped read not zero");
    out_pulse_a: assert property (out_valid |=> !out_valid)
        else $error("long pulse");
    out_hold_a: assert property ($changed(out_value) |-> out_valid)
        else $error("value moved");
    upd_send_a: assert property (in_valid && in_idx < cfg_q.n_in
        && !cfg_q.on_change && !cfg_q.dly_en && !cfg_q.lock_en
        && cfg_q.restart == RST_RECEIVED |-> ##11 out_valid)
        else $error("no send");
    req_first_a: assert property (bus_return
        && cfg_q.restart == RST_READ |-> ##2 rdreq_valid && rdreq_obj == 4'h0)
        else $error("no first request");
    req_next_a: assert property (rdreq_valid
        && rdreq_obj + 4'h1 < cfg_q.n_in
        |=> rdreq_valid && rdreq_obj == $past(rdreq_obj) + 4'h1)
        else $error("request order");
    lock_quiet_a: assert property (lock_valid && lock_value
        && cfg_q.lock_en |=> ##1 !out_valid [*8])
        else $error("send while locked");
endmodule
bind mmac_calc mmac_calc_properties #(.TICK_CYCLES(TICK_CYCLES)) u_props (
    .mclk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .bus_return, .in_valid, .in_idx, .in_value, .lock_valid, .lock_value,
    .out_valid, .out_value, .rdreq_valid, .rdreq_obj);

// File: test/tb.sv
// Self-checking bench for the value calculator
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
    n_mismatch++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb;
    import mmac_pkg::*;
    localparam int unsigned TK = 4; // Short tick
    typedef struct {mmac_mode_e m; int n; logic [7:0] e;} mmac_row_s;
    logic mclk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic bus_return = 1'b0, t_valid = 1'b0;
    logic lock_valid = 1'b0, lock_value = 1'b0;
    logic [3:0] reg_addr = 4'h0, rdreq_obj;
    logic [31:0] reg_wdata = 32'h0, t_val = 32'h0, reg_rdata, in_value;
    logic [31:0] out_value, d;
    logic [2:0] t_idx = 3'h0, in_idx;
    logic in_valid, out_valid, rdreq_valid;
    int n_mismatch = 0, check_count = 0, n_out = 0, n0;
    mmac_cfg_s c;
    logic [7:0] v [8] = '{8'h0a, 8'h28, 8'h19, 8'h46, 8'h03, 8'h5a, 8'h08,
        8'h3c};
    // Sums stay in range
    mmac_row_s rows [6] = '{'{MODE_MAX, 8, 8'h5a}, '{MODE_MIN, 8, 8'h03},
        '{MODE_MAX, 3, 8'h28}, '{MODE_MIN, 3, 8'h0a},
        '{MODE_AVG, 4, 8'h24}, '{MODE_AVG, 8, 8'h26}};
    always #50 mclk = ~mclk;
    // Output count
    always @(posedge mclk) if (out_valid === 1'b1) n_out++;
    mmac_calc #(.TICK_CYCLES(TK)) u_dut (.mclk, .sys_rst, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .bus_return, .in_valid,
        .in_idx, .in_value, .lock_valid, .lock_value, .out_valid,
        .out_value, .rdreq_valid, .rdreq_obj);
    mmac_bus_model u_bus (.mclk, .rdreq_valid, .rdreq_obj, .t_valid,
        .t_idx, .t_val, .in_valid, .in_idx, .in_value);
    task automatic wr(input logic [3:0] a, input logic [31:0] w);
        reg_addr <= a;
        reg_wdata <= w;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask
    // Data stand one cycle
    task automatic rd(input logic [3:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        @(posedge mclk);
    endtask
    // Telegram, then scan time
    task automatic send(input logic [2:0] i, input logic [7:0] x);
        t_idx <= i;
        t_val <= {24'h0, x};
        t_valid <= 1'b1;
        @(posedge mclk);
        t_valid <= 1'b0;
        t_val <= ~{24'h0, x};
        repeat (14) @(posedge mclk);
    endtask
    task automatic lk(input logic x);
        lock_value <= x;
        lock_valid <= 1'b1;
        @(posedge mclk);
        lock_valid <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic br(input int n);
        bus_return <= 1'b1;
        @(posedge mclk);
        bus_return <= 1'b0;
        repeat (n) @(posedge mclk);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        rd(ADDR_CFG);
        `CHK("cfg reset", 32'(CFG_RST), d)
        rd(ADDR_TIME);
        `CHK("time reset", 32'(TIME_RST), d)
        rd(4'h9);
        `CHK("unmapped", 32'h0, d)
        foreach (rows[r]) begin
            c = CFG_RST;
            c.fmt = FMT_U8;
            c.mode = rows[r].m;
            c.n_in = rows[r].n[3:0];
            wr(ADDR_CFG, c);
            n0 = n_out;
            for (int i = 0; i < rows[r].n; i++) send(i[2:0], v[i]);
            `CHK("result", {24'h0, rows[r].e}, out_value)
            `CHK("sends", n0 + rows[r].n, n_out)
        end
        c.mode = MODE_MAX;
        c.n_in = 4'h2;
        c.on_change = 1'b1;
        wr(ADDR_CFG, c);
        n0 = n_out;
        send(1, 8'h28);
        send(0, 8'h11);
        send(1, 8'h50);
        `CHK("change sends", n0 + 2, n_out)
        c.on_change = 1'b0;
        c.restart = RST_BLOCK;
        wr(ADDR_CFG, c);
        br(4);
        n0 = n_out;
        send(0, 8'h01);
        `CHK("blocked", n0, n_out)
        send(1, 8'h02);
        `CHK("unblocked", n0 + 1, n_out)
        c.restart = RST_READ;
        wr(ADDR_CFG, c);
        n0 = n_out;
        br(40);
        `CHK("read answers", 32'h15, out_value)
        `CHK("read sent", 1'b1, n_out > n0)
        c.restart = RST_RECEIVED;
        c.dly_en = 1'b1;
        c.dly_unit = UNIT_SEC;
        wr(ADDR_CFG, c);
        wr(ADDR_TIME, 32'h0102);
        n0 = n_out;
        send(0, 8'h33);
        `CHK("delay wait", n0, n_out)
        repeat (20) @(posedge mclk);
        `CHK("delay send", n0 + 1, n_out)
        c.dly_en = 1'b0;
        c.lock_en = 1'b1;
        wr(ADDR_CFG, c);
        lk(1'b1);
        n0 = n_out;
        send(0, 8'h44);
        `CHK("locked", n0, n_out)
        lk(1'b0);
        send(0, 8'h45);
        `CHK("unlocked", n0 + 1, n_out)
        c.lock_restart = LOCK_READ;
        wr(ADDR_CFG, c);
        n0 = n_out;
        br(1);
        send(0, 8'h46);
        `CHK("lock wait", n0, n_out)
        repeat (16) @(posedge mclk);
        send(0, 8'h47);
        `CHK("lock fallback", n0 + 1, n_out)
        finish_test();
    end
endmodule
